// ---- rtl/fslas_pkg.sv ----
// package for the queue status, drain and linked autosleep block
// assumes an ahb-lite bus with 32-bit data and one clock at 200 mhz
package fslas_pkg;
    // ==========================================================
    // register indexes; offsets are not all word multiples, byte address is 4x index
    localparam logic [7:0]  IDX_INT_CAUSE   = 8'h30;
    localparam logic [7:0]  IDX_AXIS_OUT    = 8'h32;
    localparam logic [7:0]  IDX_QUEUE_CTRL  = 8'h38;
    localparam logic [7:0]  IDX_QUEUE_STATE = 8'h39;
    localparam logic [7:0]  IDX_LINK_CTRL   = 8'h3a;
    localparam logic [7:0]  IDX_RATE_CTRL   = 8'h3b;
    localparam logic [7:0]  IDX_SAMPLE_IN   = 8'h3c;
    localparam logic [7:0]  IDX_THRESH      = 8'h3d;
    // ==========================================================
    // field positions
    localparam int TRIG_FLAG_BIT  = 7;
    localparam int INT_ACT_BIT    = 4;
    localparam int INT_INACT_BIT  = 3;
    localparam int INT_READY_BIT  = 7;
    localparam int LNK_LINK_BIT   = 0;
    localparam int LNK_AUTOS_BIT  = 1;
    localparam int LNK_SLEEP_BIT  = 2;
    localparam int LNK_ACTEN_BIT  = 3;
    localparam int LNK_INAEN_BIT  = 4;
    // ==========================================================
    // sizes and reset values
    localparam int QUEUE_DEPTH    = 32;
    localparam int QUEUE_CNT_W    = 6;
    localparam int SAMPLE_W       = 48;
    localparam logic [7:0]  QCTRL_RST = 8'h00;
    localparam logic [7:0]  LINK_RST  = 8'h18;
    localparam logic [7:0]  RATE_RST  = 8'h04;
    localparam logic [15:0] THRESH_RST = 16'h0100;
    localparam logic [3:0]  SLEEP_DIV = 4'h8;
    localparam logic [1:0]  MODE_BYPASS  = 2'h0;
    localparam logic [1:0]  MODE_FIFO    = 2'h1;
    localparam logic [1:0]  MODE_STREAM  = 2'h2;
    localparam logic [1:0]  MODE_TRIGGER = 2'h3;
    // ==========================================================
    // carrier and state types
    typedef struct packed {
        logic [15:0] z;
        logic [15:0] y;
        logic [15:0] x;
    } fslas_sample_t;
    typedef enum logic [1:0] {
        PWR_AWAKE  = 2'b00,
        PWR_SLEEP  = 2'b01,
        PWR_WAKING = 2'b11
    } fslas_pwr_t;
endpackage

// ---- rtl/fslas_fifo.sv ----
// parameterised valid/ready queue built from flip-flops
// assumes one clock and a synchronous active high reset
`timescale 1ns/1ps
module fslas_fifo #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 32,
    parameter int CNT_W = 6
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic      [WIDTH-1:0] o_out_data,
    input  wire logic             i_flush,
    output logic      [CNT_W-1:0] o_count
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_reg;
    logic [AW-1:0]    rd_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic             push;
    logic             pop;

    // handshake terms, full and empty taken from the true count
    // a pop in the same cycle frees the slot, so a full queue can recycle
    assign o_in_ready  = (cnt_reg != CNT_W'(DEPTH)) || i_out_ready;
    assign o_out_valid = (cnt_reg != '0);
    assign push        = i_in_valid & o_in_ready;
    assign pop         = o_out_valid & i_out_ready;
    assign o_out_data  = mem_reg[rd_reg];
    assign o_count     = cnt_reg;

    // storage, no reset needed on the data path
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_reg[wr_reg] <= i_in_data;
        end
    end

    // pointers and occupancy
    always_ff @(posedge i_clk) begin
        if (i_rst || i_flush) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + CNT_W'(push) - CNT_W'(pop);
        end
    end
endmodule // fslas_fifo

// ---- rtl/fslas_top.sv ----
// queue status, axis drain and linked autosleep sequencing, ahb-lite slave
// assumes a single master, word transfers only, samples on a valid strobe
//
// Contract
// - trigger-seen flag reads 1 after a queue trigger, 0 before any
// - occupancy field equals the number of samples held right now
// - queued samples leave through the x, y, z axis outputs, or are dropped as oldest in stream and pre-trigger windows, or flushed in bypass
// - any axis output read retires one level; host reads a sample at once, but each read here returns one byte and retires the whole sample
// - queue holds 32 samples plus one at the output, 33 readable
// - lower rates come from decimating one common sampling strobe
// - activity is judged on the undecimated sample stream
// - with linking, activity is searched only after inactivity
// - no autosleep while an activity interrupt is uncleared
// - sleep, autosleep and link together sleep on inactivity
// - entering sleep disables inactivity and enables activity detection
// - activity while asleep restores the rate and raises activity
// - after linked activity, activity is disabled, inactivity enabled
// - low power mode keeps sample-ready and queue filling going
// - queue state at 0x39: flag in bit 7, count in low bits
// - trigger mode keeps pre-trigger samples then fills to full
`timescale 1ns/1ps
module fslas_top #(
    parameter int DEPTH  = fslas_pkg::QUEUE_DEPTH,
    parameter int CNT_W  = fslas_pkg::QUEUE_CNT_W
) (
    input  wire logic        I_CLK_SYS,
    input  wire logic        I_RST,
    input  wire logic        I_HSEL,
    input  wire logic [31:0] I_HADDR,
    input  wire logic [1:0]  I_HTRANS,
    input  wire logic        I_HWRITE,
    input  wire logic [2:0]  I_HSIZE,
    input  wire logic [31:0] I_HWDATA,
    input  wire logic        I_HREADY,
    output logic      [31:0] O_HRDATA,
    output logic             O_HREADYOUT,
    output logic             O_HRESP,
    input  wire logic        I_SAMPLE_STROBE,
    input  wire fslas_pkg::fslas_sample_t I_SAMPLE,
    input  wire logic        I_TRIGGER,
    input  wire logic        I_ACT_DETECT,
    input  wire logic        I_INACT_DETECT,
    output logic             O_SAMPLE_READY,
    output logic             O_ASLEEP
);
    // ==========================================================
    // bus slave: address phase capture
    logic        ap_valid_reg;
    logic        ap_write_reg;
    logic [7:0]  ap_addr_reg;
    logic        wr_en;
    logic        rd_en;

    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            ap_valid_reg <= 1'b0;
            ap_write_reg <= 1'b0;
            ap_addr_reg  <= 8'h00;
        end else if (I_HREADY) begin
            ap_valid_reg <= I_HSEL & I_HTRANS[1];
            ap_write_reg <= I_HWRITE;
            ap_addr_reg  <= I_HADDR[9:2];   // word index
        end
    end
    assign O_HREADYOUT = 1'b1;               // zero wait states
    assign O_HRESP     = 1'b0;               // always okay
    assign wr_en       = ap_valid_reg & ap_write_reg;
    assign rd_en       = ap_valid_reg & ~ap_write_reg;

    // ==========================================================
    // control registers
    logic [7:0]  qctrl_reg;
    logic [7:0]  link_reg;
    logic [7:0]  rate_reg;
    logic [15:0] thresh_reg;
    logic [1:0]  qmode;
    logic [4:0]  qsamples;
    assign qmode    = qctrl_reg[7:6];
    assign qsamples = qctrl_reg[4:0];

    // software writes, link bits also moved by the sequencer below
    logic act_hit;
    logic inact_hit;
    logic sleep_enter;
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            qctrl_reg  <= fslas_pkg::QCTRL_RST;
            rate_reg   <= fslas_pkg::RATE_RST;
            thresh_reg <= fslas_pkg::THRESH_RST;
        end else if (wr_en) begin
            case (ap_addr_reg)
                fslas_pkg::IDX_QUEUE_CTRL: qctrl_reg  <= I_HWDATA[7:0];
                fslas_pkg::IDX_RATE_CTRL:  rate_reg   <= I_HWDATA[7:0];
                fslas_pkg::IDX_THRESH:     thresh_reg <= I_HWDATA[15:0];
                default: ;
            endcase
        end
    end

    // enables swap on linked events; hardware swap wins over a write
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            link_reg <= fslas_pkg::LINK_RST;
        end else if (link_reg[fslas_pkg::LNK_LINK_BIT] && act_hit) begin
            link_reg[fslas_pkg::LNK_ACTEN_BIT] <= 1'b0;
            link_reg[fslas_pkg::LNK_INAEN_BIT] <= 1'b1;
        end else if (link_reg[fslas_pkg::LNK_LINK_BIT] && inact_hit) begin
            link_reg[fslas_pkg::LNK_INAEN_BIT] <= 1'b0;
            link_reg[fslas_pkg::LNK_ACTEN_BIT] <= 1'b1;
        end else if (wr_en && ap_addr_reg == fslas_pkg::IDX_LINK_CTRL) begin
            link_reg <= I_HWDATA[7:0];
        end
    end

    // ==========================================================
    // rate divider: one common strobe decimated for output rates
    logic [7:0] dec_cnt_reg;
    logic [7:0] dec_limit;
    logic       out_tick;
    fslas_pkg::fslas_pwr_t pwr_reg;
    assign dec_limit = (pwr_reg == fslas_pkg::PWR_SLEEP)
                       ? (rate_reg << fslas_pkg::SLEEP_DIV[1:0]) : rate_reg;
    assign out_tick  = I_SAMPLE_STROBE && (dec_cnt_reg >= dec_limit);
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            dec_cnt_reg <= 8'h00;
        end else if (I_SAMPLE_STROBE) begin
            dec_cnt_reg <= out_tick ? 8'h00 : dec_cnt_reg + 8'h01;
        end
    end

    // ==========================================================
    // activity on raw strobes, not decimated output
    function automatic logic [15:0] fslas_abs(input logic [15:0] v);
        fslas_abs = v[15] ? (~v + 16'h0001) : v;
    endfunction
    logic raw_over;
    assign raw_over = (fslas_abs(I_SAMPLE.x) > thresh_reg) ||
                      (fslas_abs(I_SAMPLE.y) > thresh_reg) ||
                      (fslas_abs(I_SAMPLE.z) > thresh_reg);
    assign act_hit   = link_reg[fslas_pkg::LNK_ACTEN_BIT] &&
                       ((I_SAMPLE_STROBE && raw_over) || I_ACT_DETECT);
    assign inact_hit = link_reg[fslas_pkg::LNK_INAEN_BIT] && I_INACT_DETECT;

    // ==========================================================
    // interrupt cause flags, cleared by reading 0x30; set wins
    logic act_flag_reg;
    logic inact_flag_reg;
    logic cause_rd;
    assign cause_rd = rd_en && (ap_addr_reg == fslas_pkg::IDX_INT_CAUSE);
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            act_flag_reg   <= 1'b0;
            inact_flag_reg <= 1'b0;
        end else begin
            act_flag_reg   <= act_hit | (act_flag_reg & ~cause_rd);
            inact_flag_reg <= inact_hit | (inact_flag_reg & ~cause_rd);
        end
    end

    // ==========================================================
    // power sequencer: awake -> sleep on inactivity, wake on activity
    logic sleep_ok;
    assign sleep_ok    = link_reg[fslas_pkg::LNK_SLEEP_BIT] &
                         link_reg[fslas_pkg::LNK_AUTOS_BIT] &
                         link_reg[fslas_pkg::LNK_LINK_BIT];
    assign sleep_enter = sleep_ok && inact_hit && !act_flag_reg;
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            pwr_reg <= fslas_pkg::PWR_AWAKE;
        end else begin
            case (pwr_reg)
                fslas_pkg::PWR_AWAKE:
                    if (sleep_enter) pwr_reg <= fslas_pkg::PWR_SLEEP;
                fslas_pkg::PWR_SLEEP:
                    if (act_hit) pwr_reg <= fslas_pkg::PWR_WAKING;
                fslas_pkg::PWR_WAKING:
                    pwr_reg <= fslas_pkg::PWR_AWAKE;   // original rate back
                default: pwr_reg <= fslas_pkg::PWR_AWAKE;
            endcase
        end
    end
    assign O_ASLEEP = (pwr_reg == fslas_pkg::PWR_SLEEP);

    // ==========================================================
    // queue path: output stage holds one, fifo holds 32 more
    fslas_pkg::fslas_sample_t q_out;
    fslas_pkg::fslas_sample_t out_reg;
    logic                     out_full_reg;
    logic                     q_in_ready;
    logic                     q_out_valid;
    logic                     q_pop;
    logic                     q_push;
    logic [CNT_W-1:0]         q_count;
    logic                     trig_reg;
    logic [CNT_W-1:0]         total;
    logic                     axis_rd;
    logic                     drop_old;

    assign axis_rd = rd_en && (ap_addr_reg >= fslas_pkg::IDX_AXIS_OUT) &&
                     (ap_addr_reg <= fslas_pkg::IDX_AXIS_OUT + 8'h05);
    // stream and pre-trigger windows drop the oldest when over budget
    // stream tests the count, not ready, since ready now depends on the pop
    assign drop_old = ((qmode == fslas_pkg::MODE_STREAM) &&
                       (q_count == CNT_W'(DEPTH))) ||
                      ((qmode == fslas_pkg::MODE_TRIGGER) && !trig_reg &&
                       (q_count >= CNT_W'(qsamples)));
    assign q_push = out_tick && (qmode != fslas_pkg::MODE_BYPASS) &&
                    out_full_reg;
    assign q_pop  = q_out_valid && (axis_rd || !out_full_reg ||
                    (q_push && drop_old));

    fslas_fifo #(
        .WIDTH (fslas_pkg::SAMPLE_W),
        .DEPTH (DEPTH),
        .CNT_W (CNT_W)
    ) u_queue (
        .i_clk       (I_CLK_SYS),
        .i_rst       (I_RST),
        .i_in_valid  (q_push),
        .o_in_ready  (q_in_ready),
        .i_in_data   (I_SAMPLE),
        .o_out_valid (q_out_valid),
        .i_out_ready (q_pop),
        .o_out_data  (q_out),
        .i_flush     (qmode == fslas_pkg::MODE_BYPASS),
        .o_count     (q_count)
    );

    // output stage refill: queue first, else direct sample
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            out_reg      <= '0;
            out_full_reg <= 1'b0;
        end else if (q_out_valid && (axis_rd || !out_full_reg)) begin
            out_reg      <= q_out;
            out_full_reg <= 1'b1;
        end else if (out_tick && (!out_full_reg ||
                     qmode == fslas_pkg::MODE_BYPASS)) begin
            out_reg      <= I_SAMPLE;
            out_full_reg <= 1'b1;
        end else if (axis_rd) begin
            out_full_reg <= 1'b0;
        end
    end

    // trigger-seen flag, armed in trigger mode only
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST || qmode != fslas_pkg::MODE_TRIGGER) begin
            trig_reg <= 1'b0;
        end else if (I_TRIGGER) begin
            trig_reg <= 1'b1;
        end
    end

    assign total          = q_count + CNT_W'(out_full_reg);
    assign O_SAMPLE_READY = out_full_reg;

    // ==========================================================
    // read mux, decoded from the registered address into the data phase answer
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (ap_addr_reg)
            fslas_pkg::IDX_INT_CAUSE:
                rd_mux = {24'h0, out_full_reg, 2'b00, act_flag_reg,
                          inact_flag_reg, 3'b000};
            8'h32: rd_mux = {24'h0, out_reg.x[7:0]};
            8'h33: rd_mux = {24'h0, out_reg.x[15:8]};
            8'h34: rd_mux = {24'h0, out_reg.y[7:0]};
            8'h35: rd_mux = {24'h0, out_reg.y[15:8]};
            8'h36: rd_mux = {24'h0, out_reg.z[7:0]};
            8'h37: rd_mux = {24'h0, out_reg.z[15:8]};
            fslas_pkg::IDX_QUEUE_CTRL: rd_mux = {24'h0, qctrl_reg};
            fslas_pkg::IDX_QUEUE_STATE:
                rd_mux = {24'h0, trig_reg, 1'b0, total};
            fslas_pkg::IDX_LINK_CTRL:  rd_mux = {24'h0, link_reg};
            fslas_pkg::IDX_RATE_CTRL:  rd_mux = {24'h0, rate_reg};
            fslas_pkg::IDX_THRESH:     rd_mux = {16'h0, thresh_reg};
            default: rd_mux = 32'h0000_0000;
        endcase
    end
    assign O_HRDATA = rd_en ? rd_mux : 32'h0000_0000;

    // ==========================================================
    // checks
    a_count_bound: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        total <= CNT_W'(DEPTH + 1)) else $error("count over 33");
    a_trig_hold: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        trig_reg && qmode == fslas_pkg::MODE_TRIGGER |=> trig_reg)
        else $error("trigger flag dropped");
    a_read_retire: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        axis_rd && !q_out_valid && !out_tick |=> !out_full_reg)
        else $error("axis read did not retire");
    a_no_sleep_act: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        $rose(O_ASLEEP) |-> !$past(act_flag_reg))
        else $error("slept with activity pending");
    sequence s_sleep_req;
        sleep_ok && inact_hit && !act_flag_reg && pwr_reg == fslas_pkg::PWR_AWAKE;
    endsequence
    a_sleep_enter: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        s_sleep_req |=> O_ASLEEP) else $error("no sleep on inactivity");
    a_swap_inact: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        link_reg[0] && inact_hit && !act_hit |=> link_reg[3] && !link_reg[4])
        else $error("enables not swapped");
    a_wake: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        O_ASLEEP && act_hit |=> ##1 pwr_reg == fslas_pkg::PWR_AWAKE)
        else $error("no wake on activity");
    a_swap_act: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        link_reg[0] && act_hit |=> !link_reg[3] && link_reg[4])
        else $error("activity not disabled");
    a_cause_clear: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        cause_rd && !act_hit |=> !act_flag_reg)
        else $error("cause read did not clear");
    // stream overflow recycles the oldest slot instead of refusing the sample
    a_stream_keep: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        qmode == fslas_pkg::MODE_STREAM && q_push |-> q_in_ready)
        else $error("stream sample refused");
    // pre-trigger window: once at its size every push drops one old sample
    a_pretrig_cap: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        qmode == fslas_pkg::MODE_TRIGGER && !trig_reg && q_push && drop_old
        |=> q_count == $past(q_count))
        else $error("pre-trigger window grew");
    // flag is meaningless outside trigger mode, so it must read zero there
    a_trig_clear: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        qmode != fslas_pkg::MODE_TRIGGER |=> !trig_reg)
        else $error("trigger flag outside trigger mode");
    // a decimated sample leaves sample-ready set two cycles later
    a_ready_kept: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        out_tick |=> ##1 O_SAMPLE_READY)
        else $error("sample lost from output stage");
endmodule // fslas_top

// ---- bench/fslas_host.sv ----
// host processor model: an ahb-lite master issuing single word transfers
// assumes one slave whose hreadyout is the bus hready, rising edge clock
`timescale 1ns/1ps
module fslas_host (
    input  wire logic        i_clk,
    input  wire logic        i_hready,
    input  wire logic [31:0] i_hrdata,
    output logic             o_hsel,
    output logic      [31:0] o_haddr,
    output logic      [1:0]  o_htrans,
    output logic             o_hwrite,
    output logic      [2:0]  o_hsize,
    output logic      [31:0] o_hwdata
);
    // ==========================================================
    // idle bus from time zero
    initial begin
        o_hsel   = 1'b0;
        o_haddr  = 32'h0;
        o_htrans = 2'h0;
        o_hwrite = 1'b0;
        o_hsize  = 3'h2;
        o_hwdata = 32'h0;
    end
    // one transfer, entered just after a rising edge; byte address is 4x index
    task automatic xfer(input logic wr, input logic [7:0] idx,
                        input logic [31:0] wd, output logic [31:0] rd);
        begin
            o_hsel   <= 1'b1;
            o_haddr  <= {22'h0, idx, 2'b00};
            o_htrans <= 2'h2;
            o_hwrite <= wr;
            o_hsize  <= 3'h2;
            @(posedge i_clk);
            while (i_hready !== 1'b1) @(posedge i_clk);
            o_htrans <= 2'h0;
            o_hwdata <= wd;
            @(posedge i_clk);
            while (i_hready !== 1'b1) @(posedge i_clk);
            rd = i_hrdata;
        end
    endtask
endmodule // fslas_host

// ---- bench/fifo_status_link_autosleep_tb.sv ----
// self-checking bench for the queue status, drain and linked autosleep block
// assumes the host model drives the ahb side; sensor inputs come from here
`timescale 1ns/1ps
module fifo_status_link_autosleep_tb;
    logic I_CLK_SYS = 1'b0, I_RST = 1'b1, I_HSEL, I_HWRITE, O_HREADYOUT, O_HRESP;
    logic [31:0] I_HADDR, I_HWDATA, O_HRDATA;
    logic [1:0]  I_HTRANS;
    logic [2:0]  I_HSIZE;
    logic I_SAMPLE_STROBE = 1'b0, I_TRIGGER = 1'b0, I_ACT_DETECT = 1'b0;
    logic I_INACT_DETECT = 1'b0, O_SAMPLE_READY, O_ASLEEP;
    fslas_pkg::fslas_sample_t I_SAMPLE = '0;
    int n_mismatch = 0, tests_run = 0, cycles = 0;
    logic [31:0] d;
    // ==========================================================
    // clock and cycle-count timeout
    always #2.5 I_CLK_SYS = ~I_CLK_SYS;
    always @(posedge I_CLK_SYS) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    fslas_top fslas_top_inst (.I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .I_HSEL(I_HSEL),
        .I_HADDR(I_HADDR), .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE), .I_HSIZE(I_HSIZE),
        .I_HWDATA(I_HWDATA), .I_HREADY(O_HREADYOUT), .O_HRDATA(O_HRDATA),
        .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP), .I_SAMPLE_STROBE(I_SAMPLE_STROBE),
        .I_SAMPLE(I_SAMPLE), .I_TRIGGER(I_TRIGGER), .I_ACT_DETECT(I_ACT_DETECT),
        .I_INACT_DETECT(I_INACT_DETECT), .O_SAMPLE_READY(O_SAMPLE_READY),
        .O_ASLEEP(O_ASLEEP));
    fslas_host fslas_host_inst (.i_clk(I_CLK_SYS), .i_hready(O_HREADYOUT),
        .i_hrdata(O_HRDATA), .o_hsel(I_HSEL), .o_haddr(I_HADDR), .o_htrans(I_HTRANS),
        .o_hwrite(I_HWRITE), .o_hsize(I_HSIZE), .o_hwdata(I_HWDATA));
    // ==========================================================
    // comparisons and bus helpers
    task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: register read %h, wanted %h", $time, got, exp);
        end
    endtask
    task automatic check_pin(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: pin %b, wanted %b", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] idx);
        fslas_host_inst.xfer(1'b0, idx, 32'h0, d);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] v);
        logic [31:0] unused;
        fslas_host_inst.xfer(1'b1, idx, v, unused);
    endtask
    // n raw samples, one every other cycle; x low byte numbers them
    task automatic strobe(input int n);
        for (int i = 0; i < n; i++) begin
            I_SAMPLE_STROBE <= 1'b1;
            I_SAMPLE <= {16'h3000 + 16'(i), 16'h2000 + 16'(i), 8'h10, 8'(i)};
            @(posedge I_CLK_SYS);
            I_SAMPLE_STROBE <= 1'b0;
            @(posedge I_CLK_SYS);
        end
    endtask
    task automatic pulse(input int which);
        if (which == 0) I_ACT_DETECT <= 1'b1; else I_INACT_DETECT <= 1'b1;
        @(posedge I_CLK_SYS);
        I_ACT_DETECT <= 1'b0;
        I_INACT_DETECT <= 1'b0;
        @(posedge I_CLK_SYS);
    endtask
    // registered state: give it a few edges to settle before judging
    task automatic expect_asleep(input logic exp);
        repeat (8) @(posedge I_CLK_SYS);
        check_pin(O_ASLEEP, exp);
    endtask
    // ==========================================================
    // scenarios
    task automatic t_reset_values();
        rd(fslas_pkg::IDX_QUEUE_STATE); check_reg(d, 32'h0);
        rd(fslas_pkg::IDX_LINK_CTRL);   check_reg(d, 32'h18);
        rd(fslas_pkg::IDX_QUEUE_CTRL);  check_reg(d, 32'h0);
        rd(fslas_pkg::IDX_RATE_CTRL);   check_reg(d, 32'h4);
        rd(fslas_pkg::IDX_THRESH);      check_reg(d, 32'h100);
        wr(fslas_pkg::IDX_QUEUE_STATE, 32'hff);
        rd(fslas_pkg::IDX_QUEUE_STATE); check_reg(d, 32'h0);
        wr(8'h10, 32'hff);
        rd(8'h10); check_reg(d, 32'h0);
    endtask
    // overfill, then drain byte by byte: order, count and 33 ceiling
    task automatic t_fill_drain();
        wr(fslas_pkg::IDX_RATE_CTRL, 32'h0);
        wr(fslas_pkg::IDX_QUEUE_CTRL, 32'h40);
        strobe(40);
        rd(fslas_pkg::IDX_QUEUE_STATE); check_reg(d, 32'd33);
        check_pin(O_SAMPLE_READY, 1'b1);
        for (int k = 0; k < 33; k++) begin
            rd(fslas_pkg::IDX_AXIS_OUT); check_reg({24'h0, d[7:0]}, 32'(k));
            rd(fslas_pkg::IDX_QUEUE_STATE); check_reg(d, 32'(32 - k));
        end
        check_pin(O_SAMPLE_READY, 1'b0);
    endtask
    // divisor 2 keeps one raw sample in three whatever the phase
    task automatic t_decimate();
        wr(fslas_pkg::IDX_RATE_CTRL, 32'h2);
        strobe(6);
        rd(fslas_pkg::IDX_QUEUE_STATE); check_reg(d, 32'd2);
        rd(fslas_pkg::IDX_AXIS_OUT);
        rd(fslas_pkg::IDX_AXIS_OUT);
        rd(fslas_pkg::IDX_QUEUE_STATE); check_reg(d, 32'd0);
        wr(fslas_pkg::IDX_RATE_CTRL, 32'h0);
    endtask
    task automatic t_trigger();
        wr(fslas_pkg::IDX_QUEUE_CTRL, 32'hc4);
        rd(fslas_pkg::IDX_QUEUE_STATE); check_reg(d, 32'h0);
        // four kept in the queue plus the one in the output stage
        strobe(8);
        rd(fslas_pkg::IDX_QUEUE_STATE); check_reg(d, 32'd5);
        I_TRIGGER <= 1'b1;
        @(posedge I_CLK_SYS);
        I_TRIGGER <= 1'b0;
        @(posedge I_CLK_SYS);
        strobe(40);
        rd(fslas_pkg::IDX_QUEUE_STATE); check_reg(d, 32'ha1);
        // stream on a full queue: odd strobe count catches a lost slot
        wr(fslas_pkg::IDX_QUEUE_CTRL, 32'h80);
        strobe(3);
        rd(fslas_pkg::IDX_QUEUE_STATE); check_reg(d, 32'd33);
    endtask
    // sleep is used only for power sequencing here, never to acquire
    task automatic t_linked();
        wr(fslas_pkg::IDX_LINK_CTRL, 32'h17);
        // earlier raw strobes above threshold left activity pending
        rd(fslas_pkg::IDX_INT_CAUSE);
        check_pin(d[fslas_pkg::INT_ACT_BIT], 1'b1);
        pulse(0);
        rd(fslas_pkg::IDX_INT_CAUSE);
        check_pin(d[fslas_pkg::INT_ACT_BIT], 1'b0);
        pulse(1);
        expect_asleep(1'b1);
        rd(fslas_pkg::IDX_LINK_CTRL); check_reg(d, 32'h0f);
        rd(fslas_pkg::IDX_INT_CAUSE); check_pin(d[fslas_pkg::INT_INACT_BIT], 1'b1);
        rd(fslas_pkg::IDX_INT_CAUSE); check_pin(d[fslas_pkg::INT_INACT_BIT], 1'b0);
        pulse(0);
        expect_asleep(1'b0);
        rd(fslas_pkg::IDX_LINK_CTRL); check_reg(d, 32'h17);
        pulse(1);
        expect_asleep(1'b0);
        rd(fslas_pkg::IDX_INT_CAUSE); check_pin(d[fslas_pkg::INT_ACT_BIT], 1'b1);
        // that inactivity swapped the search back to activity; re-arm it
        wr(fslas_pkg::IDX_LINK_CTRL, 32'h17);
        pulse(1);
        expect_asleep(1'b1);
    endtask
    // ==========================================================
    // closing report, the only place the run ends
    task automatic give_verdict();
        $display("mismatches %0d, comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // main sequence: three-cycle reset, then each scenario in turn
    initial begin
        repeat (3) @(posedge I_CLK_SYS);
        I_RST <= 1'b0;
        @(posedge I_CLK_SYS);
        t_reset_values();
        t_fill_drain();
        t_decimate();
        t_trigger();
        t_linked();
        give_verdict();
    end
endmodule // fifo_status_link_autosleep_tb
